// File: design/acrd_consts.svh
// Timing constants, widths and tap positions for the chain readout block.
`ifndef ACRD_CONSTS_SVH
`define ACRD_CONSTS_SVH

`define ACRD_RESULT_BITS   18
`define ACRD_SHIFT_BITS    19
`define ACRD_FIFO_DEPTH    8
`define ACRD_SYS_CLK_NS    100
`define ACRD_CONV_TIME_NS  2200
`define ACRD_CONV_CYCLES   ((`ACRD_CONV_TIME_NS + `ACRD_SYS_CLK_NS - 1) / `ACRD_SYS_CLK_NS)
`define ACRD_TAP_BUSY      18
`define ACRD_TAP_PLAIN     17

`endif

// File: design/acrd_pkg.sv
// Types shared by the chain readout design.
package acrd_pkg;

   typedef enum logic [3:0]
   {
      ACRD_ST_IDLE = 4'b0001,
      ACRD_ST_CONV = 4'b0010,
      ACRD_ST_LOAD = 4'b0100,
      ACRD_ST_READ = 4'b1000
   } acrd_state_e;

   typedef logic [17:0] acrd_result_t;

endpackage

// File: design/acrd_fifo.sv
// Result FIFO between the converter core and the readout shift register.
`timescale 1ns/1ps
`default_nettype none
module acrd_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_reg != DEPTH[AW:0]);
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem_reg[rd_ptr_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Storage array is written only on an accepted push.
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointers wrap naturally since the depth is a power of two.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // Fill level tracks simultaneous push and pop.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_reg <= '0;
      end
      else if (push && !pop)
      begin
         count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
         count_reg <= count_reg - 1'b1;
      end
   end

endmodule
`default_nettype wire

// File: design/acrd_top.sv
// Daisy-chain serial readout of an 18-bit converter with optional busy indication.
// Functional notes
// - With data input and conversion start both low, drive data output low.
// - Start edge with serial clock high starts conversion, chain mode, busy indication on.
// - Start edge with serial clock low starts conversion, chain mode, busy indication off.
// - When the whole chain is done, nearest device drives data output high.
// - After conversion the device returns to acquisition and powers down.
// - Result shifts out most significant bit first on serial clock falling edges.
// - Data input enters the shift register on each falling edge, passing upstream data.
`timescale 1ns/1ps
`default_nettype none
`include "acrd_consts.svh"
module acrd_top
   import acrd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        serial_clock_i,
   input  wire logic        conversion_start_i,
   input  wire logic        serial_data_in_i,
   input  wire logic [17:0] sample_data_i,
   input  wire logic        sample_valid_i,
   output logic             sample_ready_o,
   output logic             serial_data_out_o,
   output logic             serial_data_out_oe_n_o,
   output logic             chain_busy_mode_o,
   output logic             converting_o,
   output logic             power_down_o
);

   localparam logic [7:0] CONV_CYCLES = 8'(`ACRD_CONV_CYCLES);

   acrd_state_e          state_reg;
   logic [2:0]           cnv_sync_reg;
   logic [2:0]           sdi_sync_reg;
   logic [2:0]           sck_sync_reg;
   logic                 cnv_lvl_reg;
   logic                 sdi_lvl_reg;
   logic                 sck_lvl_reg;
   logic                 cnv_rise;
   logic                 cnv_fall;
   logic [7:0]           conv_cnt_reg;
   logic                 busy_mode_reg;
   logic [18:0]          word_reg;
   logic                 load_tgl_reg;
   logic [1:0]           ack_sync_reg;
   logic                 sys_pending;
   logic                 gate_reg;
   logic                 drive_low_reg;
   logic                 release_reg;
   logic                 ready_reg;
   logic                 conv_reg;
   logic                 pd_reg;
   acrd_result_t         fifo_data;
   logic                 fifo_valid;
   logic                 fifo_pop;
   logic                 fifo_in_ready;
   logic [1:0]           lrst_sync_reg;
   logic [18:0]          shift_reg;
   logic                 ack_tgl_reg;
   logic                 link_pending;
   logic                 tap_bit;

   function automatic logic filt(input logic [2:0] s, input logic lvl);
      filt = (s[1] == s[2]) ? s[2] : lvl;
   endfunction
   function automatic logic tap(input logic [18:0] v, input logic busy);
      tap = busy ? v[`ACRD_TAP_BUSY] : v[`ACRD_TAP_PLAIN];
   endfunction

   acrd_fifo
   #(
      .WIDTH (`ACRD_RESULT_BITS),
      .DEPTH (`ACRD_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_i       (sys_clk_i),
      .rst_i       (sys_rst_i),
      .in_data_i   (sample_data_i),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // Pin inputs pass three flip-flops; a level counts when stages two and three agree.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         cnv_sync_reg <= 3'h0;
         sdi_sync_reg <= 3'h0;
         sck_sync_reg <= 3'h0;
         cnv_lvl_reg  <= 1'b0;
         sdi_lvl_reg  <= 1'b0;
         sck_lvl_reg  <= 1'b0;
      end
      else
      begin
         cnv_sync_reg <= {cnv_sync_reg[1:0], conversion_start_i};
         sdi_sync_reg <= {sdi_sync_reg[1:0], serial_data_in_i};
         sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_i};
         cnv_lvl_reg  <= filt(cnv_sync_reg, cnv_lvl_reg);
         sdi_lvl_reg  <= filt(sdi_sync_reg, sdi_lvl_reg);
         sck_lvl_reg  <= filt(sck_sync_reg, sck_lvl_reg);
      end
   end

   assign cnv_rise = filt(cnv_sync_reg, cnv_lvl_reg) && !cnv_lvl_reg;
   assign cnv_fall = !filt(cnv_sync_reg, cnv_lvl_reg) && cnv_lvl_reg;

   // Acknowledge toggle from the link domain crosses on two flip-flops.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_sync_reg <= 2'h0;
      end
      else
      begin
         ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
      end
   end

   assign sys_pending = (load_tgl_reg != ack_sync_reg[1]);
   assign fifo_pop    = (state_reg == ACRD_ST_LOAD) && fifo_valid;

   // Conversion sequencer; waits in the load state if no result is queued.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         state_reg    <= ACRD_ST_IDLE;
         conv_cnt_reg <= 8'h00;
      end
      else
      begin
         case (state_reg)
            ACRD_ST_IDLE:
            begin
               if (cnv_rise)
               begin
                  state_reg    <= ACRD_ST_CONV;
                  conv_cnt_reg <= CONV_CYCLES;
               end
            end
            ACRD_ST_CONV:
            begin
               if (conv_cnt_reg <= 8'h01)
               begin
                  state_reg <= ACRD_ST_LOAD;
               end
               conv_cnt_reg <= conv_cnt_reg - 8'h01;
            end
            ACRD_ST_LOAD:
            begin
               if (fifo_valid)
               begin
                  state_reg <= ACRD_ST_READ;
               end
            end
            ACRD_ST_READ:
            begin
               if (cnv_fall)
               begin
                  state_reg <= ACRD_ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ACRD_ST_IDLE;
            end
         endcase
      end
   end

   // Serial clock level at the start edge selects busy indication.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         busy_mode_reg <= 1'b0;
      end
      else if ((state_reg == ACRD_ST_IDLE) && cnv_rise)
      begin
         busy_mode_reg <= sck_lvl_reg;
      end
   end

   // The whole result is captured before any indication or shifting.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         word_reg     <= 19'h00000;
         load_tgl_reg <= 1'b0;
      end
      else if (fifo_pop)
      begin
         word_reg     <= {busy_mode_reg, fifo_data};
         load_tgl_reg <= load_tgl_reg ^ !sys_pending;
      end
   end

   // Output gate opens once the result is held and, with busy indication on, the upstream chain is done.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         gate_reg <= 1'b0;
      end
      else if (state_reg != ACRD_ST_READ)
      begin
         gate_reg <= 1'b0;
      end
      else if (!busy_mode_reg || sdi_lvl_reg)
      begin
         gate_reg <= 1'b1;
      end
   end

   // Pin drive control and status flags.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         drive_low_reg <= 1'b0;
         release_reg   <= 1'b1;
         ready_reg     <= 1'b0;
         conv_reg      <= 1'b0;
         pd_reg        <= 1'b1;
      end
      else
      begin
         drive_low_reg <= !cnv_lvl_reg && !sdi_lvl_reg;
         release_reg   <= !cnv_lvl_reg && sdi_lvl_reg;
         ready_reg     <= fifo_in_ready;
         conv_reg      <= (state_reg == ACRD_ST_CONV) || (state_reg == ACRD_ST_LOAD);
         pd_reg        <= (state_reg == ACRD_ST_IDLE) || (state_reg == ACRD_ST_READ);
      end
   end

   // Link-domain reset is resynchronised onto serial clock falling edges.
   always_ff @(negedge serial_clock_i)
   begin
      lrst_sync_reg <= {lrst_sync_reg[0], sys_rst_i};
   end
   assign link_pending = (load_tgl_reg != ack_tgl_reg);

   // The held word is stable while pending, so the first falling edge may take it directly.
   always_ff @(negedge serial_clock_i)
   begin
      if (lrst_sync_reg[1])
      begin
         shift_reg   <= 19'h00000;
         ack_tgl_reg <= 1'b0;
      end
      else if (link_pending)
      begin
         shift_reg   <= {word_reg[17:0], serial_data_in_i};
         ack_tgl_reg <= ~ack_tgl_reg;
      end
      else
      begin
         shift_reg <= {shift_reg[17:0], serial_data_in_i};
      end
   end

   assign tap_bit = link_pending ? tap(word_reg, busy_mode_reg) : tap(shift_reg, busy_mode_reg);

   assign sample_ready_o         = ready_reg;
   assign serial_data_out_o      = (gate_reg && !drive_low_reg) ? tap_bit : 1'b0;
   assign serial_data_out_oe_n_o = release_reg;
   assign chain_busy_mode_o      = busy_mode_reg;
   assign converting_o           = conv_reg;
   assign power_down_o           = pd_reg;

endmodule
`default_nettype wire

// File: verification/acrd_top_properties.sv
// Checker on the chain readout top ports.
`timescale 1ns/1ps
`default_nettype none
`include "acrd_consts.svh"
module acrd_chk
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic serial_clock_i,
   input wire logic conversion_start_i,
   input wire logic serial_data_in_i,
   input wire logic serial_data_out_o,
   input wire logic serial_data_out_oe_n_o,
   input wire logic chain_busy_mode_o,
   input wire logic converting_o,
   input wire logic power_down_o
);
   logic [7:0] cnt_reg;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !converting_o)
         cnt_reg <= 8'h00;
      else if (cnt_reg != 8'hff)
         cnt_reg <= cnt_reg + 8'h01;
   end
   sequence s_idle;
      (!conversion_start_i && !serial_data_in_i) [*6];
   endsequence
   sequence s_done;
      ##[0:6] serial_data_out_o && !serial_data_out_oe_n_o;
   endsequence
   a_idle_drive_low: assert property (s_idle |-> !serial_data_out_oe_n_o && !serial_data_out_o)
      else $error("output not driven low");
   a_busy_mode_on: assert property ($rose(converting_o) && serial_clock_i |-> ##[0:2] chain_busy_mode_o)
      else $error("busy mode not set");
   a_busy_mode_off: assert property ($rose(converting_o) && !serial_clock_i |-> ##[0:2] !chain_busy_mode_o)
      else $error("busy mode not clear");
   a_conv_length: assert property ($fell(converting_o) |-> int'(cnt_reg) >= `ACRD_CONV_CYCLES - 1)
      else $error("conversion too short");
   a_power_after: assert property ($fell(converting_o) |-> ##[0:2] power_down_o)
      else $error("no power down");
   a_power_conv: assert property (converting_o |-> !power_down_o)
      else $error("power down in conversion");
   a_done_high: assert property ($fell(converting_o) && chain_busy_mode_o && serial_data_in_i |-> s_done)
      else $error("no completion level");
   a_quiet_conv: assert property (converting_o |-> !serial_data_out_o)
      else $error("output high in conversion");
endmodule
bind acrd_top acrd_chk u_acrd_chk (.*);
`default_nettype wire

// File: verification/acrd_host_model.sv
// Host model driving start, link clock and upstream data.
`timescale 1ns/1ps
`default_nettype none
module acrd_host_model
(
   output logic      sclk_o,
   output logic      start_o,
   output logic      up_o,
   input  wire logic dout_i
);
   initial
   begin
      sclk_o = 1'b0;
      start_o = 1'b0;
      up_o = 1'b0;
   end
   task automatic set_up(input logic v);
      up_o = v;
   endtask
   task automatic pulses();
      repeat (4)
      begin
         #6 sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
      end
   endtask
   task automatic frame(input logic busy, input int n, input logic [36:0] din, output logic [36:0] cap);
      cap = '0;
      sclk_o = busy;
      up_o = busy;
      #500;
      start_o = 1'b1;
      #4000;
      for (int k = 0; k < n; k++)
      begin
         sclk_o = 1'b1;
         cap[36-k] = dout_i;
         #1 up_o = din[36-k];
         #5 sclk_o = 1'b0;
         #6;
      end
      #300 start_o = 1'b0;
      up_o = 1'b0;
      #700;
   endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the chain readout top.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import acrd_pkg::*;
   ;
   logic        clk;
   logic        rst;
   logic [17:0] s_data;
   logic        s_valid;
   logic        s_ready;
   logic        dout;
   logic        doe_n;
   logic        busy_m;
   logic        conv;
   logic        pdn;
   wire logic   sclk_w;
   wire logic   start_w;
   wire logic   up_w;
   int          num_errors;
   int          checks_done;
   acrd_top u_acrd_top
   (
      .sys_clk_i              (clk),
      .sys_rst_i              (rst),
      .serial_clock_i         (sclk_w),
      .conversion_start_i     (start_w),
      .serial_data_in_i       (up_w),
      .sample_data_i          (s_data),
      .sample_valid_i         (s_valid),
      .sample_ready_o         (s_ready),
      .serial_data_out_o      (dout),
      .serial_data_out_oe_n_o (doe_n),
      .chain_busy_mode_o      (busy_m),
      .converting_o           (conv),
      .power_down_o           (pdn)
   );
   acrd_host_model u_acrd_host_model
   (
      .sclk_o  (sclk_w),
      .start_o (start_w),
      .up_o    (up_w),
      .dout_i  (dout)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function automatic acrd_result_t wd(input int i);
      return acrd_result_t'(18'h3ffff ^ (i * 18'h0a5c3));
   endfunction
   task automatic push(input acrd_result_t w);
      int t;
      t = 0;
      s_data = w;
      s_valid = 1'b1;
      while (s_ready !== 1'b1 && t < 50)
      begin
         @(posedge clk);
         #1 t++;
      end
      if (t >= 50)
      begin
         num_errors++;
         results();
      end
      @(posedge clk);
      #1 s_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic t_idle();
      repeat (8) @(posedge clk);
      #1;
      chk(doe_n, 1'b0);
      chk(dout, 1'b0);
      chk(pdn, 1'b1);
      $display("test idle done");
   endtask
   task automatic t_release();
      u_acrd_host_model.set_up(1'b1);
      repeat (8) @(posedge clk);
      #1;
      chk(doe_n, 1'b1);
      chk(dout, 1'b0);
      u_acrd_host_model.set_up(1'b0);
      repeat (8) @(posedge clk);
      #1;
      chk(doe_n, 1'b0);
      $display("test release done");
   endtask
   task automatic t_fill();
      for (int i = 0; i < 8; i++)
         push(wd(i));
      chk(s_ready, 1'b0);
      $display("test fill done");
   endtask
   task automatic t_read(input int i);
      logic        busy;
      logic [36:0] cap;
      logic [36:0] exp;
      busy = i[0];
      exp = busy ? {1'b1, wd(i), 18'h00000} : {wd(i), ~wd(i), 1'b0};
      fork
         u_acrd_host_model.frame(busy, busy ? 19 : 36, busy ? 37'h1fffffffff : {~wd(i), 19'h00000}, cap);
         begin
            repeat (20) @(posedge clk);
            #1;
            chk(conv, 1'b1);
            chk(pdn, 1'b0);
         end
      join
      chk(cap, exp);
      chk(busy_m, busy);
      chk(pdn, 1'b1);
      chk(s_ready, 1'b1);
      repeat (8) @(posedge clk);
      #1;
      chk(doe_n, 1'b0);
      chk(dout, 1'b0);
      $display("test read %0d done", i);
   endtask
   initial
   begin
      rst = 1'b1;
      s_data = 18'h00000;
      s_valid = 1'b0;
      num_errors = 0;
      checks_done = 0;
      u_acrd_host_model.pulses();
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      u_acrd_host_model.pulses();
      t_idle();
      t_release();
      t_fill();
      for (int i = 0; i < 8; i++)
         t_read(i);
      results();
   end
endmodule
`default_nettype wire
